//--- src/epc_pkg.sv
package epc_pkg;

  // Register byte offsets
  localparam logic [7:0] EPC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] EPC_OFF_STATUS = 8'h04;
  localparam logic [7:0] EPC_OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] EPC_OFF_IRQ_MK = 8'h0c;

  // Control field positions
  localparam int EPC_CTRL_HANDSHAKE = 0;
  localparam int EPC_CTRL_AIS_SEL   = 1;
  localparam int EPC_CTRL_ALLOW     = 2;

  // Reset values
  localparam logic [2:0] EPC_CTRL_RST = 3'h4;
  localparam logic [3:0] EPC_MASK_RST = 4'h0;

  // Interrupt bit positions
  localparam int EPC_IRQ_CHANGE = 0;
  localparam int EPC_IRQ_LOS    = 1;
  localparam int EPC_IRQ_AIS    = 2;
  localparam int EPC_IRQ_POWER  = 3;

  // Debounce time and cycles at 25 MHz
  localparam int EPC_CLK_HZ      = 25000000;
  localparam int EPC_DEBOUNCE_US = 10;
  localparam int EPC_DEBOUNCE_CYC = EPC_DEBOUNCE_US * (EPC_CLK_HZ / 1000000);

  // Power-up settle time before claiming service
  localparam int EPC_SETTLE_US  = 100;
  localparam int EPC_SETTLE_CYC = EPC_SETTLE_US * (EPC_CLK_HZ / 1000000);

  // AXI response codes
  localparam logic [1:0] EPC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EPC_RESP_SLVERR = 2'h2;

  // Role states, Gray along the usual path
  typedef enum logic [1:0] {
    EPC_ST_SETTLE  = 2'h0,
    EPC_ST_STANDBY = 2'h1,
    EPC_ST_SERVICE = 2'h3
  } epc_state_t;

  // Front panel lamps
  typedef struct packed {
    logic service;
    logic standby;
    logic data_loss;
    logic ais;
  } epc_leds_t;

  // Alarm contacts, high means closed
  typedef struct packed {
    logic power_ok;
    logic signal_ok;
  } epc_contacts_t;

endpackage

//--- src/epc_sync.sv
`timescale 1ns/10ps
module epc_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two flip-flop synchroniser
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // epc_sync

//--- src/epc_debounce.sv
`timescale 1ns/10ps
module epc_debounce
  import epc_pkg::*;
#(
  parameter int COUNT = EPC_DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Synchronised level in, stable level and press pulse out
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise_out
);

  localparam int CW = $clog2(COUNT + 1);

  initial begin
    if (COUNT < 1) $error("epc_debounce: COUNT must be at least 1");
  end

  logic [CW-1:0] cnt_reg;
  logic          stable_reg;
  logic          rise_reg;
  wire           differs = (level_in != stable_reg);
  wire           expired = (cnt_reg == CW'(COUNT - 1));

  // Accept a new level once it held for COUNT cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg    <= '0;
      stable_reg <= 1'b0;
      rise_reg   <= 1'b0;
    end else begin
      cnt_reg    <= (differs && !expired) ? cnt_reg + 1'b1 : '0;
      stable_reg <= (differs && expired) ? level_in : stable_reg;
      rise_reg   <= differs && expired && level_in;
    end
  end

  assign level_out = stable_reg;
  assign rise_out  = rise_reg;

endmodule // epc_debounce

//--- src/epc_changeover.sv
// Function
// - Stand-alone: copy the single line input to all four outputs.
// - Without power, relays bypass line input directly to output 1.
// - Loss-of-power alarm plus general alarm on LOS or AIS; alarm opens contact.
// - Stand-alone: green service lamp on valid input, red lamps for data loss and AIS.
// - Stand-alone: standby lamp always dark.
// - Handshake: automatic input selection only while both toggles allow change.
// - Auto changeover on in-service LOS, and on AIS when option enabled.
// - Change-inhibit blocks automatic and manual changeover.
// - At power-up exactly one card becomes in-service, other standby.
// - Handshake: own alarm contacts and an external changeover request input.
// - Remote tally shows which card is in-service.
// - Handshake: service or standby lamp by role, plus data-loss and AIS lamps.
// - AIS changeover select enables AIS switching only in handshake mode.
`timescale 1ns/10ps
module epc_changeover
  import epc_pkg::*;
#(
  parameter int      DEBOUNCE_CYC = EPC_DEBOUNCE_CYC,
  parameter int      SETTLE_CYC   = EPC_SETTLE_CYC,
  parameter bit      SLOT_ONE     = 1'b1
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  // Line data
  input  wire logic                line_in,
  input  wire logic                partner_line_in,
  output logic [3:0]               line_out,
  output logic                     bypass_relay_out,
  // Detectors and power monitor (asynchronous)
  input  wire logic                los_in,
  input  wire logic                ais_in,
  input  wire logic                power_good_in,
  // Panel and rear controls (asynchronous)
  input  wire logic                manual_press_in,
  input  wire logic                allow_toggle_in,
  input  wire logic                ext_request_n_in,
  input  wire logic                handshake_strap_in,
  input  wire logic [7:0]          user_dip_switch_bank_in,
  // Partner card handshake (asynchronous)
  input  wire logic                partner_service_in,
  input  wire logic                partner_allow_in,
  input  wire logic                partner_present_in,
  output logic                     service_claim_out,
  output logic                     allow_out,
  // Indicators and contacts
  output epc_leds_t                leds_out,
  output epc_contacts_t            contacts_out,
  output logic [1:0]               tally_n_out,
  output logic                     irq_out,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  initial begin
    if (SETTLE_CYC < 1) $error("epc_changeover: SETTLE_CYC must be at least 1");
  end

  localparam int SW = $clog2(SETTLE_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  ////////////////////////////////////////////////////////////////////////////

  logic [10:0] raw_sync;
  logic [7:0]  dip_sync;
  logic        man_lvl, man_rise, ext_lvl, ext_rise;

  epc_sync #(.WIDTH(11)) u_sync_ctl (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({los_in, ais_in, power_good_in, manual_press_in, allow_toggle_in,
                !ext_request_n_in, handshake_strap_in, partner_service_in,
                partner_allow_in, partner_present_in, 1'b0}),
    .sync_out (raw_sync)
  );

  epc_sync #(.WIDTH(8)) u_sync_dip (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (user_dip_switch_bank_in),
    .sync_out (dip_sync)
  );

  wire los_s      = raw_sync[10];
  wire ais_s      = raw_sync[9];
  wire pwr_s      = raw_sync[8];
  wire allow_s    = raw_sync[6];
  wire hs_strap_s = raw_sync[4];
  wire p_serv_s   = raw_sync[3];
  wire p_allow_s  = raw_sync[2];
  wire p_pres_s   = raw_sync[1];

  // Debounce manual press and grounded external request
  epc_debounce #(.COUNT(DEBOUNCE_CYC)) u_db_man (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (raw_sync[7]),
    .level_out (man_lvl),
    .rise_out  (man_rise)
  );

  epc_debounce #(.COUNT(DEBOUNCE_CYC)) u_db_ext (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (raw_sync[5]),
    .level_out (ext_lvl),
    .rise_out  (ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register and mode decode
  ////////////////////////////////////////////////////////////////////////////

  logic [2:0] ctrl_reg;
  logic [3:0] irq_st_reg, irq_mk_reg;

  // Handshake mode needs the strap, a partner card present and the handshake control bit
  wire handshake = hs_strap_s && p_pres_s && ctrl_reg[EPC_CTRL_HANDSHAKE];
  // AIS switching option: DIP switch or software, handshake only
  wire ais_sel   = dip_sync[3] || ctrl_reg[EPC_CTRL_AIS_SEL];
  wire both_allow = allow_s && p_allow_s && ctrl_reg[EPC_CTRL_ALLOW];
  wire fault     = los_s || (ais_sel && ais_s);
  wire manual_req = handshake && both_allow && (man_rise || ext_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Role state machine
  ////////////////////////////////////////////////////////////////////////////

  epc_state_t    state_reg, state_next;
  logic [SW-1:0] settle_reg;
  wire           settled = (settle_reg == SW'(SETTLE_CYC));
  // Slot one wins power-up contention, slot two defers to a live partner
  wire           may_claim = !p_serv_s;

  // Next role
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EPC_ST_SETTLE: begin
        if (settled) begin
          state_next = (SLOT_ONE && may_claim) ? EPC_ST_SERVICE : EPC_ST_STANDBY;
        end
      end
      EPC_ST_STANDBY: begin
        // A request takes over and the partner yields; stand-alone serves unless the partner claims service
        if (manual_req || (may_claim && !handshake)) begin
          state_next = EPC_ST_SERVICE;
        end
      end
      EPC_ST_SERVICE: begin
        if (handshake && both_allow && fault && !ext_lvl && !man_lvl) begin
          state_next = EPC_ST_STANDBY;
        end else if (handshake && p_serv_s && !SLOT_ONE) begin
          state_next = EPC_ST_STANDBY;
        end
      end
      default: state_next = EPC_ST_SETTLE;
    endcase
  end

  // Role register and power-up settle counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg  <= EPC_ST_SETTLE;
      settle_reg <= '0;
    end else begin
      state_reg  <= state_next;
      settle_reg <= settled ? settle_reg : settle_reg + 1'b1;
    end
  end

  wire in_service = (state_reg == EPC_ST_SERVICE);
  // Stand-alone always drives its own input; handshake only when main
  wire drive_own  = !handshake || in_service;
  // Tally pins, active low: own slot and the partner's slot
  wire tally_own  = !(handshake && in_service);
  wire tally_peer = !(handshake && p_serv_s);

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  epc_leds_t     leds_next;
  epc_contacts_t cont_next;
  logic          line_sel;

  assign line_sel  = drive_own ? line_in : partner_line_in;
  assign leds_next = '{service:   handshake ? in_service : !los_s,
                       standby:   handshake && !in_service,
                       data_loss: los_s,
                       ais:       ais_s};
  assign cont_next = '{power_ok: pwr_s, signal_ok: !(los_s || ais_s)};

  // Registered line, lamps, contacts, tally and handshake lines
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_out          <= '0;
      bypass_relay_out  <= 1'b1;
      leds_out          <= '0;
      contacts_out      <= '0;
      tally_n_out       <= 2'h3;
      service_claim_out <= 1'b0;
      allow_out         <= 1'b0;
    end else begin
      line_out          <= {4{line_sel}};
      bypass_relay_out  <= !pwr_s;
      leds_out          <= leds_next;
      contacts_out      <= cont_next;
      tally_n_out       <= SLOT_ONE ? {tally_peer, tally_own} : {tally_own, tally_peer};
      service_claim_out <= handshake && in_service;
      allow_out         <= allow_s && ctrl_reg[EPC_CTRL_ALLOW];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events
  ////////////////////////////////////////////////////////////////////////////

  logic [3:0] ev_prev_reg;
  wire  [3:0] ev_now  = {!pwr_s, ais_s, los_s, in_service};
  wire  [3:0] ev_edge = {ev_now[3:1] & ~ev_prev_reg[3:1], ev_now[0] ^ ev_prev_reg[0]};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  ////////////////////////////////////////////////////////////////////////////

  logic       aw_got, w_got;
  logic [7:0] aw_reg;
  logic [31:0] w_reg;
  wire  wr_fire  = aw_got && w_got && !s_axi_bvalid;
  wire  wr_ctrl  = wr_fire && (aw_reg == EPC_OFF_CTRL) && w_reg[31];
  wire  wr_clr   = wr_fire && (aw_reg == EPC_OFF_IRQ_ST);
  wire  wr_mask  = wr_fire && (aw_reg == EPC_OFF_IRQ_MK);
  wire  wr_ok    = wr_ctrl || wr_clr || wr_mask || (aw_reg == EPC_OFF_CTRL);
  wire  rd_ok    = (s_axi_araddr == EPC_OFF_CTRL) || (s_axi_araddr == EPC_OFF_STATUS) ||
                   (s_axi_araddr == EPC_OFF_IRQ_ST) || (s_axi_araddr == EPC_OFF_IRQ_MK);
  wire  [31:0] status_word = {24'h0, dip_sync[3], handshake, both_allow, fault,
                              pwr_s, ais_s, los_s, in_service};
  wire  [31:0] rd_mux =
    (s_axi_araddr == EPC_OFF_CTRL)   ? {29'h0, ctrl_reg} :
    (s_axi_araddr == EPC_OFF_STATUS) ? status_word :
    (s_axi_araddr == EPC_OFF_IRQ_ST) ? {28'h0, irq_st_reg} :
    (s_axi_araddr == EPC_OFF_IRQ_MK) ? {28'h0, irq_mk_reg} : 32'h0;

  // Write channel capture and response
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_reg <= '0;
      w_reg  <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= EPC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_reg <= {s_axi_wstrb[0], s_axi_wdata[30:0]};
      end
      if (wr_fire) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? EPC_RESP_OKAY : EPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers: control, mask, sticky status (set wins over clear)
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg    <= EPC_CTRL_RST;
      irq_mk_reg  <= EPC_MASK_RST;
      irq_st_reg  <= '0;
      ev_prev_reg <= 4'h8; // Power reads lost until the synchroniser fills
      irq_out     <= 1'b0;
    end else begin
      ev_prev_reg <= ev_now;
      if (wr_ctrl) ctrl_reg <= w_reg[2:0];
      if (wr_mask && w_reg[31]) irq_mk_reg <= w_reg[3:0];
      irq_st_reg  <= (irq_st_reg & ~((wr_clr && w_reg[31]) ? w_reg[3:0] : 4'h0)) | ev_edge;
      irq_out     <= |(irq_st_reg & irq_mk_reg);
    end
  end

  // Read channel
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= EPC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? EPC_RESP_OKAY : EPC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // epc_changeover

//--- testbench/epc_changeover_sva.sv
`timescale 1ns/10ps
module epc_changeover_sva
  import epc_pkg::*;
(
  // Clock and reset
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  // Line, detectors and toggles
  input wire logic          line_in,
  input wire logic          partner_line_in,
  input wire logic [3:0]    line_out,
  input wire logic          bypass_relay_out,
  input wire logic          los_in,
  input wire logic          ais_in,
  input wire logic          power_good_in,
  input wire logic          allow_toggle_in,
  input wire logic          partner_service_in,
  // Role and indicators
  input wire logic          service_claim_out,
  input wire epc_leds_t     leds_out,
  input wire epc_contacts_t contacts_out,
  input wire logic [1:0]    tally_n_out,
  // Write response
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////////////
  // Input conditions held long enough to cross the synchronisers
  sequence s_power_lost; !power_good_in [*5]; endsequence
  sequence s_los_held; los_in [*5]; endsequence
  sequence s_ais_held; ais_in [*5]; endsequence
  sequence s_inhibit; !allow_toggle_in [*4]; endsequence
  sequence s_main_held; service_claim_out [*7]; endsequence
  //////////////////////////////////////////////////////////////////////////////
  // Outputs against their causes
  a_line_copy: assert property (
    $past(rst_n_in) && !$past(bypass_relay_out) && !$past(partner_service_in)
    && $past(line_in) == $past(partner_line_in) |-> line_out == {4{$past(line_in)}})
    else $error("line outputs differ from line input");
  a_bypass_loss: assert property (s_power_lost |-> bypass_relay_out)
    else $error("bypass relay not engaged on power loss");
  a_power_alarm: assert property (s_power_lost |-> !contacts_out.power_ok)
    else $error("power contact closed while power lost");
  a_signal_alarm: assert property (
    s_los_held |-> !contacts_out.signal_ok && leds_out.data_loss)
    else $error("signal loss not shown");
  a_ais_lamp: assert property (s_ais_held |-> leds_out.ais && !contacts_out.signal_ok)
    else $error("AIS not shown");
  a_roles_lamp: assert property (!(leds_out.service && leds_out.standby))
    else $error("service and standby lamps both lit");
  a_tally_main: assert property (s_main_held |-> tally_n_out == 2'h2)
    else $error("tally does not show this card as main");
  a_inhibit_keeps: assert property (
    s_inhibit ##0 service_claim_out |=> service_claim_out)
    else $error("role changed under change-inhibit");
  a_bvalid_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule // epc_changeover_sva

bind epc_changeover epc_changeover_sva u_sva (
  .clk_in, .rst_n_in, .line_in, .partner_line_in, .line_out, .bypass_relay_out,
  .los_in, .ais_in, .power_good_in, .allow_toggle_in, .partner_service_in,
  .service_claim_out, .leds_out, .contacts_out, .tally_n_out, .s_axi_bvalid, .s_axi_bready
);

//--- testbench/epc_partner_card.sv
`timescale 1ns/10ps
module epc_partner_card (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Local card role and peer toggle
  input  wire logic dut_claim_in,
  input  wire logic allow_in,
  // Handshake towards the local card
  output logic      service_out,
  output logic      allow_out,
  output logic      present_out,
  output logic      line_out
);
  logic       seen_reg;
  logic [7:0] lfsr_reg;
  // Pseudo-random line data, never parked at a level
  assign line_out    = lfsr_reg[0];
  assign present_out = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  // Peer role: yields to a claim, takes over once the local card drops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      service_out <= 1'b0;
      allow_out   <= 1'b0;
      seen_reg    <= 1'b0;
      lfsr_reg    <= 8'h5b;
    end else begin
      seen_reg  <= dut_claim_in;
      allow_out <= allow_in;
      lfsr_reg  <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      if (dut_claim_in) begin
        service_out <= 1'b0;
      end else if (seen_reg) begin
        service_out <= 1'b1;
      end
    end
  end
endmodule // epc_partner_card

//--- testbench/test_e1_protection_changeover_control.sv
`timescale 1ns/10ps
module test_e1_protection_changeover_control
  import epc_pkg::*;
;
  // Stimulus
  logic          clk_in, rst_n_in, line_in, los_in, ais_in, power_good_in, peer_allow;
  logic          manual_press_in, allow_toggle_in, ext_request_n_in, handshake_strap_in;
  logic [7:0]    user_dip_switch_bank_in, s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, seed, q;
  logic [3:0]    s_axi_wstrb;
  logic          s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  // Observed
  logic          partner_line_in, partner_service_in, partner_allow_in, partner_present_in;
  logic [3:0]    line_out;
  logic          bypass_relay_out, service_claim_out, allow_out, irq_out;
  epc_leds_t     leds_out;
  epc_contacts_t contacts_out;
  logic [1:0]    tally_n_out, s_axi_bresp, s_axi_rresp, rp;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]   s_axi_rdata;
  int            err_count, compares, cyc;

  epc_changeover #(.DEBOUNCE_CYC(4), .SETTLE_CYC(8), .SLOT_ONE(1'b1)) dut (.*);
  epc_partner_card u_peer (.clk_in, .rst_n_in, .dut_claim_in(service_claim_out),
    .allow_in(peer_allow), .service_out(partner_service_in), .allow_out(partner_allow_in),
    .present_out(partner_present_in), .line_out(partner_line_in));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic wait_role(input logic v);
    for (int i = 0; i < 80 && service_claim_out !== v; i++) @(negedge clk_in);
    idle(6);
  endtask
  task automatic pulse_press(input bit ext);
    @(posedge clk_in);
    if (ext)
      ext_request_n_in <= 1'b0;
    else
      manual_press_in <= 1'b1;
    idle(12);
    @(posedge clk_in);
    ext_request_n_in <= 1'b1;
    manual_press_in  <= 1'b0;
    idle(12);
  endtask
  // One AXI4-Lite transfer, holding each channel until its own ready
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tv, pa, pw;
    @(posedge clk_in);
    pa = 1'b1;
    pw = wr;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    while (pa || pw) begin
      @(negedge clk_in);
      ta = wr ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      @(posedge clk_in);
      if (ta) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw && wr) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk_in);
      tv = wr ? s_axi_bvalid : s_axi_rvalid;
      q  = s_axi_rdata;
      rp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_in);
    end while (!tv);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n_in, line_in, los_in, ais_in, manual_press_in} = 5'h0;
    {power_good_in, allow_toggle_in, ext_request_n_in, handshake_strap_in, peer_allow} = 5'h1f;
    user_dip_switch_bank_in = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    seed = 32'h22;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    idle(12);
    chk(32'({leds_out.service, leds_out.standby}), 32'h2);
    // Stand-alone: random data fans out to all four outputs
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      @(posedge clk_in);
      line_in <= seed[0];
      user_dip_switch_bank_in <= {seed[15:12], 1'b0, seed[10:8]};
      @(posedge clk_in);
      @(negedge clk_in);
      chk(32'(line_out), 32'({4{seed[0]}}));
    end
    pulse_press(1'b0);
    chk(32'(service_claim_out), 32'h0);
    // Power loss, then each detector with interrupts still masked
    @(posedge clk_in);
    power_good_in <= 1'b0;
    idle(8);
    chk(32'({bypass_relay_out, contacts_out.power_ok}), 32'h2);
    @(posedge clk_in);
    power_good_in <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      los_in <= (k == 0);
      ais_in <= (k == 1);
      idle(8);
      chk(32'({leds_out.data_loss, leds_out.ais, contacts_out.signal_ok, irq_out}),
          k ? 32'h4 : 32'h8);
      chk(32'(leds_out.standby), 32'h0);
    end
    @(posedge clk_in);
    ais_in <= 1'b0;
    // Registers: reset value, refusals, mask and write-one-to-clear
    bus(1'b0, EPC_OFF_CTRL, 32'h0);
    chk(q, 32'(EPC_CTRL_RST));
    bus(1'b0, 8'h10, 32'h0);
    chk(32'(rp), 32'(EPC_RESP_SLVERR));
    bus(1'b1, EPC_OFF_STATUS, 32'hff);
    chk(32'(rp), 32'(EPC_RESP_SLVERR));
    bus(1'b1, EPC_OFF_IRQ_MK, 32'h2);
    idle(3);
    chk(32'(irq_out), 32'h1);
    bus(1'b1, EPC_OFF_IRQ_ST, 32'h2);
    idle(3);
    chk(32'(irq_out), 32'h0);
    bus(1'b0, EPC_OFF_IRQ_ST, 32'h0);
    chk(q & 32'he, 32'hc);
    // Handshake with AIS switching: power-up role, then changeover and back
    bus(1'b1, EPC_OFF_CTRL, 32'h7);
    wait_role(1'b1);
    chk(32'({service_claim_out, tally_n_out, leds_out.service, leds_out.standby}),
        32'h1a);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      ais_in <= (k == 0);
      los_in <= (k == 1);
      wait_role(1'b0);
      chk(32'({service_claim_out, leds_out.standby, tally_n_out}), 32'h5);
      @(posedge clk_in);
      ais_in <= 1'b0;
      los_in <= 1'b0;
      pulse_press(k == 1);
      wait_role(1'b1);
      chk(32'(service_claim_out), 32'h1);
    end
    // Inhibit on either card holds the role through a fault
    @(posedge clk_in);
    peer_allow <= 1'b0;
    idle(8);
    @(posedge clk_in);
    los_in <= 1'b1;
    idle(40);
    chk(32'(service_claim_out), 32'h1);
    @(posedge clk_in);
    allow_toggle_in <= 1'b0;
    idle(8);
    @(posedge clk_in);
    peer_allow <= 1'b1;
    idle(40);
    chk(32'(service_claim_out), 32'h1);
    @(posedge clk_in);
    allow_toggle_in <= 1'b1;
    wait_role(1'b0);
    chk(32'(service_claim_out), 32'h0);
    @(posedge clk_in);
    los_in <= 1'b0;
    allow_toggle_in <= 1'b0;
    pulse_press(1'b0);
    idle(20);
    chk(32'(service_claim_out), 32'h0);
    @(posedge clk_in);
    allow_toggle_in <= 1'b1;
    pulse_press(1'b0);
    wait_role(1'b1);
    chk(32'(service_claim_out), 32'h1);
    // AIS switching off until the select switch is set
    bus(1'b1, EPC_OFF_CTRL, 32'h5);
    @(posedge clk_in);
    ais_in <= 1'b1;
    idle(40);
    chk(32'(service_claim_out), 32'h1);
    @(posedge clk_in);
    user_dip_switch_bank_in[3] <= 1'b1;
    wait_role(1'b0);
    chk(32'(service_claim_out), 32'h0);
    print_verdict();
  end
endmodule // test_e1_protection_changeover_control
